// ---- src/fir_fold_regs.vh ----
// Constants for the folded lookup-table filter datapath
`ifndef FIR_FOLD_REGS_VH
`define FIR_FOLD_REGS_VH

// Datapath widths and sizes
`define IN_W 8
`define OP_W 9
`define CF_W 8
`define NT 4'h8
`define NT_LOG 3
`define KMAX 4'h4
`define HIST_LEN 32
`define ACC_W 24
`define CNT_W 4
`define W_PLAIN 4'h8
`define W_FOLD 4'h9

// Reset values
`define RST_L 4'h8
`define RST_BPC 4'h1

// Coefficient structure codes
`define ST_NONSYM 2'h0
`define ST_SYM 2'h1
`define ST_NEGSYM 2'h2

// Filter type codes
`define FT_SINGLE 2'h0
`define FT_HALFBAND 2'h1
`define FT_HILBERT 2'h2
`define FT_ZEROPACK 2'h3

// Largest useful bit slice: a whole folded operand per clock
`define BPC_MAX 4'h9

`endif

// ---- src/fir_fold.v ----
// Folded lookup-table FIR datapath with symmetry, half-band and Hilbert forms
`timescale 1ns/100ps
`include "fir_fold_regs.vh"

module fir_fold (
  input wire clk_sys,
  input wire rst,
  input wire in_valid,
  input wire [`IN_W-1:0] in_data,
  output reg in_ready,
  input wire coef_wr,
  input wire [`NT_LOG-1:0] coef_addr,
  input wire [`CF_W-1:0] coef_data,
  input wire [`CNT_W-1:0] n_taps,
  input wire [1:0] filter_type,
  input wire struct_force_en,
  input wire [1:0] struct_force,
  input wire [`CNT_W-1:0] bits_per_clock_step,
  input wire [2:0] zp_factor,
  output reg out_valid,
  output reg signed [`ACC_W-1:0] out_q,
  output reg signed [`IN_W-1:0] out_i,
  output reg [1:0] struct_used,
  output reg [`CNT_W-1:0] cycles_per_out,
  output reg [`CNT_W-1:0] taps_used
);

////////////////////////////////////////////////////////////////////////////
// Storage

reg signed [`CF_W-1:0] coef_mem [0:`NT-1];
reg signed [`IN_W-1:0] hist_r [0:`HIST_LEN-1];
reg signed [`OP_W-1:0] op_r [0:`NT-1];
reg signed [`CF_W-1:0] cf_r [0:`NT-1];
reg signed [`ACC_W-1:0] acc_r;
reg [`CNT_W-1:0] sl_r;
reg [`CNT_W-1:0] len_r;
reg [`CNT_W-1:0] bpc_r;
reg [`CNT_W-1:0] width_r;
reg busy_r;
reg signed [`IN_W-1:0] mid_r;

// Combinational working values
reg signed [`IN_W-1:0] hv [0:`HIST_LEN-1];
reg signed [`IN_W-1:0] tv [0:`NT-1];
reg signed [`CF_W-1:0] pc [0:`NT-1];
reg signed [`OP_W-1:0] op_nxt [0:`NT-1];
reg signed [`CF_W-1:0] cf_nxt [0:`NT-1];
reg [1:0] inferred;
reg [1:0] eff;
reg sym_ok;
reg neg_ok;
reg [`CNT_W-1:0] ntap;
reg [`CNT_W-1:0] front;
reg [`CNT_W-1:0] plen;
reg [`CNT_W-1:0] spacing;
reg [`CNT_W-1:0] bpc;
reg [`CNT_W-1:0] width;
reg [`CNT_W-1:0] len;
reg signed [`IN_W-1:0] mid_nxt;
reg signed [`ACC_W-1:0] part;
reg signed [`ACC_W-1:0] acc_nxt;
reg signed [`ACC_W-1:0] sv;
reg [`CNT_W-1:0] sl_nxt;
reg busy_nxt;
reg ready_nxt;
reg last;
reg accept;
integer i;
integer j;
integer d;
integer lo;
integer t;
integer u;

////////////////////////////////////////////////////////////////////////////
// Slice count: ceil(width / bits per clock)

function [`CNT_W-1:0] slices;
  input [`CNT_W-1:0] w;
  input [`CNT_W-1:0] b;
  integer q;
  begin
    q = (w + b - 1) / b;
    slices = q[`CNT_W-1:0];
  end
endfunction

////////////////////////////////////////////////////////////////////////////
// Coefficient storage written by the configuring logic

always @(posedge clk_sys)
begin
  if (coef_wr)
  begin
    coef_mem[coef_addr] <= coef_data;
  end
end

////////////////////////////////////////////////////////////////////////////
// Structure, padding and folding

always @*
begin
  accept = in_valid & in_ready;
  ntap = n_taps;
  if (ntap == 4'h0 || ntap > `NT)
    ntap = `NT;
  // Infer symmetry from the stored set
  sym_ok = 1'b1;
  neg_ok = 1'b1;
  for (i = 0; i < `NT; i = i + 1)
  begin
    if (i < ntap)
    begin
      if (coef_mem[i] != coef_mem[ntap - 1 - i])
        sym_ok = 1'b0;
      if (coef_mem[i] != -coef_mem[ntap - 1 - i])
        neg_ok = 1'b0;
    end
  end
  if (sym_ok)
    inferred = `ST_SYM;
  else if (neg_ok)
    inferred = `ST_NEGSYM;
  else
    inferred = `ST_NONSYM;
  // User override wins over the inferred structure
  if (struct_force_en)
  begin
    eff = struct_force;
  end
  else if (filter_type == `FT_HILBERT)
  begin
    eff = `ST_NEGSYM;
  end
  else
  begin
    eff = inferred;
  end
  // Symmetric padding centres the set; forced non-symmetric trails zeros
  if (eff != `ST_NONSYM)
  begin
    front = (`NT - ntap) >> 1;
    plen = ntap + (front << 1);
  end
  else
  begin
    front = 4'h0;
    plen = ntap;
  end
  // Zero-packed spacing, clamped so the deepest tap stays in history
  if (filter_type == `FT_ZEROPACK && zp_factor != 3'h0)
    spacing = (zp_factor > `KMAX) ? `KMAX : {1'b0, zp_factor};
  else
    spacing = 4'h1;
  // History including the sample being accepted
  hv[0] = in_data;
  for (i = 1; i < `HIST_LEN; i = i + 1)
  begin
    hv[i] = hist_r[i - 1];
  end
  for (i = 0; i < `NT; i = i + 1)
  begin
    tv[i] = (i < plen) ? hv[i * spacing] : 8'sh00;
    if (i >= front && i < front + ntap)
    begin
      pc[i] = coef_mem[i - front];
    end
    else
    begin
      pc[i] = 8'sh00;
    end
    // Gate the known-zero taps so they do no multiply work
    d = i - (plen - 1) / 2;
    if (plen[0] && filter_type == `FT_HALFBAND && d != 0 && d % 2 == 0)
    begin
      pc[i] = 8'sh00;
    end
    if (plen[0] && filter_type == `FT_HILBERT && d % 2 == 0)
    begin
      pc[i] = 8'sh00;
    end
  end
  mid_nxt = hv[((plen - 1) / 2) * spacing];
  // Fold mirrored pairs
  for (i = 0; i < `NT; i = i + 1)
  begin
    op_nxt[i] = 9'sh000;
    cf_nxt[i] = 8'sh00;
    if (eff == `ST_NONSYM)
    begin
      op_nxt[i] = tv[i];
      cf_nxt[i] = pc[i];
    end
    else if (i < plen / 2)
    begin
      if (eff == `ST_NEGSYM)
      begin
        op_nxt[i] = tv[i] - tv[plen - 1 - i];
      end
      else
      begin
        op_nxt[i] = tv[i] + tv[plen - 1 - i];
      end
      cf_nxt[i] = pc[i];
    end
    else if (plen[0] && i == plen / 2)
    begin
      op_nxt[i] = tv[i];
      cf_nxt[i] = pc[i];
    end
  end
  // Folded operands carry one more bit, hence one more slice when bits per clock is 1, 2, 4 or 8
  width = (eff == `ST_NONSYM) ? `W_PLAIN : `W_FOLD;
  bpc = bits_per_clock_step;
  if (bpc == 4'h0)
  begin
    bpc = 4'h1;
  end
  else if (bpc > `BPC_MAX)
  begin
    bpc = `BPC_MAX;
  end
  len = slices(width, bpc);
end

////////////////////////////////////////////////////////////////////////////
// Bit-slice weighting; the top bit of each operand is its sign

always @*
begin
  part = 24'sh000000;
  lo = sl_r * bpc_r;
  for (t = 0; t < `NT; t = t + 1)
  begin
    sv = 24'sh000000;
    for (j = 0; j < `OP_W; j = j + 1)
    begin
      if (j >= lo && j < lo + bpc_r && j < width_r && op_r[t][j])
      begin
        if (j == width_r - 1)
        begin
          sv = sv - (24'sh000001 <<< j);
        end
        else
        begin
          sv = sv + (24'sh000001 <<< j);
        end
      end
    end
    part = part + sv * cf_r[t];
  end
  last = busy_r && (sl_r == len_r - 4'h1);
  acc_nxt = ((sl_r == 4'h0) ? 24'sh000000 : acc_r) + part;
  // Sequencing; a new sample may land on the final slice
  if (accept)
  begin
    busy_nxt = 1'b1;
    sl_nxt = 4'h0;
    ready_nxt = (len == 4'h1);
  end
  else if (last || !busy_r)
  begin
    busy_nxt = 1'b0;
    sl_nxt = 4'h0;
    ready_nxt = 1'b1;
  end
  else
  begin
    busy_nxt = 1'b1;
    sl_nxt = sl_r + 4'h1;
    ready_nxt = (sl_r + 4'h2 == len_r);
  end
end

////////////////////////////////////////////////////////////////////////////
// Registers, all on the rising edge of the core clock

always @(posedge clk_sys)
begin
  if (rst)
  begin
    in_ready <= 1'b1;
    busy_r <= 1'b0;
    sl_r <= 4'h0;
    len_r <= `RST_L;
    bpc_r <= `RST_BPC;
    width_r <= `RST_L;
    acc_r <= 24'sh000000;
    mid_r <= 8'sh00;
    out_valid <= 1'b0;
    out_q <= 24'sh000000;
    out_i <= 8'sh00;
    struct_used <= `ST_NONSYM;
    cycles_per_out <= `RST_L;
    taps_used <= 4'h0;
  end
  else
  begin
    in_ready <= ready_nxt;
    busy_r <= busy_nxt;
    sl_r <= sl_nxt;
    acc_r <= acc_nxt;
    // One result per accepted sample, as a one-cycle pulse
    out_valid <= last;
    if (last)
    begin
      out_q <= acc_nxt;
      out_i <= mid_r;
    end
    if (accept)
    begin
      // Config is sampled per sample so a change never splits a result
      len_r <= len;
      bpc_r <= bpc;
      width_r <= width;
      mid_r <= mid_nxt;
      struct_used <= eff;
      cycles_per_out <= len;
      taps_used <= plen;
    end
  end
end

always @(posedge clk_sys)
begin
  if (accept)
  begin
    for (u = 0; u < `HIST_LEN; u = u + 1)
    begin
      hist_r[u] <= hv[u];
    end
    for (u = 0; u < `NT; u = u + 1)
    begin
      op_r[u] <= op_nxt[u];
      cf_r[u] <= cf_nxt[u];
    end
  end
end

endmodule // fir_fold

// ---- src/fir_fold_pad.v ----
// Empty on purpose: all filter logic lives in fir_fold.v

// ---- bench/res_sink.sv ----
// Downstream consumer model that counts filter outputs
`timescale 1ns/100ps
module res_sink (
  input wire clk_sys,
  input wire rst,
  input wire out_valid,
  output reg [15:0] n_out
);
  // Never stalls: the block has no output back-pressure to honour
  always @(posedge clk_sys)
  begin
    if (rst)
      n_out <= 16'h0000;
    else if (out_valid)
      n_out <= n_out + 16'h0001;
  end
endmodule // res_sink

// ---- bench/fir_fold_chk.sv ----
// Port-level assertions for the folded filter
`timescale 1ns/100ps
`include "fir_fold_regs.vh"
module fir_fold_chk (
  input wire clk_sys,
  input wire rst,
  input wire in_valid,
  input wire in_ready,
  input wire [1:0] filter_type,
  input wire struct_force_en,
  input wire [1:0] struct_force,
  input wire [`CNT_W-1:0] bits_per_clock_step,
  input wire out_valid,
  input wire signed [`ACC_W-1:0] out_q,
  input wire signed [`IN_W-1:0] out_i,
  input wire [1:0] struct_used,
  input wire [`CNT_W-1:0] cycles_per_out
);
  reg [3:0] since_r;
  wire take = in_valid && in_ready;
  function [3:0] lcalc(input [3:0] b, input s);
    reg [3:0] bb;
  begin
    bb = (b == 4'h0) ? 4'h1 : (b > 4'h9) ? 4'h9 : b;
    lcalc = ((s ? 5'h09 : 5'h08) + bb - 5'h01) / bb;
  end
  endfunction
  // Saturates so an idle block never looks like a pending result
  always @(posedge clk_sys)
  begin
    if (rst)
      since_r <= 4'hF;
    else if (take)
      since_r <= 4'h1;
    else if (since_r != 4'hF)
      since_r <= since_r + 4'h1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  property p_rate;
    take |=> cycles_per_out ==
      lcalc($past(bits_per_clock_step), struct_used != 2'h0);
  endproperty
  a_rate: assert property (p_rate)
    else $error("cycles per output wrong");
  property p_ready;
    in_ready == (since_r >= cycles_per_out);
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready at wrong time");
  property p_due;
    // Result registers on the edge where the count meets the cycle figure
    out_valid == $past(since_r == cycles_per_out);
  endproperty
  a_due: assert property (p_due)
    else $error("output at wrong time");
  property p_pulse;
    out_valid && cycles_per_out != 4'h1 |=> !out_valid;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("output pulse too long");
  property p_hold;
    !$past(rst) && !out_valid |-> $stable(out_q) && $stable(out_i);
  endproperty
  a_hold: assert property (p_hold)
    else $error("output changed without valid");
  property p_force;
    take && struct_force_en && struct_force != 2'h3 |=>
      struct_used == $past(struct_force);
  endproperty
  a_force: assert property (p_force)
    else $error("forced structure ignored");
  property p_hilb;
    take && filter_type == 2'h2 && !struct_force_en |=> struct_used == 2'h2;
  endproperty
  a_hilb: assert property (p_hilb)
    else $error("hilbert structure wrong");
  property p_rst;
    disable iff (1'b0) rst |=> in_ready && !out_valid &&
      cycles_per_out == 4'h8 && out_q == 24'h000000;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset state wrong");
endmodule // fir_fold_chk
bind fir_fold fir_fold_chk u_chk (.clk_sys(clk_sys), .rst(rst),
  .in_valid(in_valid), .in_ready(in_ready), .filter_type(filter_type),
  .struct_force_en(struct_force_en), .struct_force(struct_force),
  .bits_per_clock_step(bits_per_clock_step), .out_valid(out_valid),
  .out_q(out_q), .out_i(out_i), .struct_used(struct_used),
  .cycles_per_out(cycles_per_out));

// ---- bench/fir_fold_tb.sv ----
// Self-checking bench for the folded filter
`timescale 1ns/100ps
`include "fir_fold_regs.vh"
module fir_fold_tb;
  reg clk_sys = 1'b0;
  reg rst = 1'b1;
  reg in_valid = 1'b0;
  reg [`IN_W-1:0] in_data = 8'h00;
  reg coef_wr = 1'b0;
  reg [2:0] coef_addr = 3'h0;
  reg [7:0] coef_data = 8'h00;
  reg [3:0] n_taps = 4'h8;
  reg [1:0] filter_type = 2'h0;
  reg struct_force_en = 1'b0;
  reg [1:0] struct_force = 2'h0;
  reg [3:0] bits_per_clock_step = 4'h1;
  reg [2:0] zp_factor = 3'h1;
  wire in_ready, out_valid;
  wire signed [`ACC_W-1:0] out_q;
  wire signed [`IN_W-1:0] out_i;
  wire [1:0] struct_used;
  wire [3:0] cycles_per_out, taps_used;
  wire [15:0] n_out;
  integer n_fail = 0, compares = 0;
  integer j, i, c, acc, p, fr, el;
  reg signed [7:0] cf [0:7];
  reg signed [7:0] xs [0:23];
  reg [15:0] n0;
  initial forever #5 clk_sys = ~clk_sys;
  fir_fold dut (.clk_sys(clk_sys), .rst(rst), .in_valid(in_valid),
    .in_data(in_data), .in_ready(in_ready), .coef_wr(coef_wr),
    .coef_addr(coef_addr), .coef_data(coef_data), .n_taps(n_taps),
    .filter_type(filter_type), .struct_force_en(struct_force_en),
    .struct_force(struct_force), .bits_per_clock_step(bits_per_clock_step),
    .zp_factor(zp_factor), .out_valid(out_valid), .out_q(out_q),
    .out_i(out_i), .struct_used(struct_used),
    .cycles_per_out(cycles_per_out), .taps_used(taps_used));
  res_sink sink (.clk_sys(clk_sys), .rst(rst), .out_valid(out_valid),
    .n_out(n_out));
  ////////////////////////////////////////////////////////////////////////
  task chk(input [79:0] nm, input [23:0] e, input [23:0] g);
  begin
    compares = compares + 1;
    if (g !== e)
    begin
      n_fail = n_fail + 1;
      $display("wrong value %0s exp %h got %h", nm, e, g);
    end
  end
  endtask
  task report_and_stop;
  begin
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  end
  endtask
  // History is not reset, so only the last 8 samples of 24 are judged
  task run(input [63:0] cs, input [3:0] n, input [1:0] f, input fe,
    input [1:0] fs, input [3:0] b, input [2:0] k, input [1:0] e);
  begin
    for (i = 0; i < 8; i = i + 1)
    begin
      @(negedge clk_sys);
      coef_wr = 1'b1;
      coef_addr = i;
      coef_data = cs[63-8*i -: 8];
      cf[i] = cs[63-8*i -: 8];
    end
    @(negedge clk_sys);
    coef_wr = 1'b0;
    n_taps = n;
    filter_type = f;
    struct_force_en = fe;
    struct_force = fs;
    bits_per_clock_step = b;
    zp_factor = k;
    el = ((e != 2'h0 ? 9 : 8) + b - 1) / b;
    fr = (e != 2'h0) ? (8 - n) / 2 : 0;
    p = n + 2 * fr;
    n0 = n_out;
    for (j = 0; j < 24; j = j + 1)
    begin
      while (in_ready !== 1'b1) @(negedge clk_sys);
      xs[j] = j * 37 + 5;
      in_valid = 1'b1;
      in_data = xs[j];
      @(negedge clk_sys);
      chk("in_ready", el == 1, in_ready);
      in_valid = 1'b0;
      in_data = ~xs[j];
      c = 0;
      while (out_valid !== 1'b1 && c < 20)
      begin
        @(negedge clk_sys);
        c = c + 1;
      end
      acc = 0;
      for (i = 0; i < p; i = i + 1)
        if (i >= fr && i < fr + n)
          acc = acc + cf[i - fr] * xs[j - i * k];
      if (j >= 16)
      begin
        chk("out_q", acc, out_q);
        chk("out_i", xs[j - (p - 1) / 2 * k], out_i);
        chk("struct", e, struct_used);
        chk("taps", p, taps_used);
        chk("cycles", el, cycles_per_out);
        chk("latency", el, c);
      end
    end
    in_valid = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("n_out", 24, n_out - n0);
  end
  endtask
  initial
  begin
    repeat (20) @(negedge clk_sys);
    chk("in_ready", 1, in_ready);
    chk("out_valid", 0, out_valid);
    chk("cycles", 8, cycles_per_out);
    chk("struct", 0, struct_used);
    chk("taps", 0, taps_used);
    chk("out_q", 0, out_q);
    chk("out_i", 0, out_i);
    rst = 1'b0;
    run(64'h0102030405060708, 8, 0, 0, 0, 1, 1, 0);
    run(64'h03FE05FE03000000, 5, 0, 0, 0, 1, 1, 1);
    run(64'h0104FDFD04010000, 6, 0, 0, 0, 9, 1, 1);
    run(64'h02FB05FE00000000, 4, 0, 0, 0, 5, 1, 2);
    run(64'h03FE05FE03000000, 5, 0, 1, 0, 2, 1, 0);
    run(64'hFF0009100900FF00, 7, 1, 0, 0, 1, 1, 1);
    run(64'hFD00F70009000300, 7, 2, 0, 0, 9, 1, 2);
    run(64'h0102030405060708, 4, 3, 0, 0, 4, 2, 0);
    report_and_stop;
  end
  initial
  begin
    #200000;
    n_fail = n_fail + 1;
    report_and_stop;
  end
endmodule // fir_fold_tb
